// ---- common/szbt_params.svh ----
`ifndef SZBT_PARAMS_SVH
`define SZBT_PARAMS_SVH

// ****************************************
// Register offsets
// ****************************************
`define SZBT_ZONE0_OFS 16'hF984
`define SZBT_ZONE1_OFS 16'hF986
`define SZBT_ZONE2_OFS 16'hF988

// ****************************************
// Reset value and writable bits
// ****************************************
`define SZBT_CFG_RESET 16'h069F
`define SZBT_CFG_WMASK 16'h0EFF
`define SZBT_CFG_RSV_MASK 16'hF100

// ****************************************
// Field positions
// ****************************************
`define SZBT_WAIT_LSB 0
`define SZBT_HOLD_LSB 3
`define SZBT_BRE_BIT 5
`define SZBT_WBR_BIT 6
`define SZBT_BW_BIT 7
`define SZBT_IDLE_AFTER_ZONE_CHANGE_BIT 9
`define SZBT_IDLE_BEFORE_ZONE_CHANGE_BIT 10
`define SZBT_FRE_BIT 11

// ****************************************
// Zone codes
// ****************************************
`define SZBT_IO_ZONE 2'h3

`endif

// ---- common/szbt_pkg.sv ----
package szbt_pkg;

	// ****************************************
	// Zone configuration layout
	// ****************************************
	typedef struct packed {
		logic [3:0] rsv_hi;
		logic fast_read_enable;
		logic idle_before_zone_change;
		logic idle_after_zone_change;
		logic rsv8;
		logic bus_width_select;
		logic burst_wait_add;
		logic burst_read_enable;
		logic [1:0] hold_cnt;
		logic [2:0] wait_cnt;
	} szbt_zone_cfg_t;

	// ****************************************
	// Bus cycle phases
	// ****************************************
	typedef enum logic [7:0] {
		SZBT_READY = 8'h01,
		SZBT_IDLE = 8'h02,
		SZBT_T1 = 8'h04,
		SZBT_T2 = 8'h08,
		SZBT_WAIT = 8'h10,
		SZBT_BWAIT = 8'h20,
		SZBT_BEAT = 8'h40,
		SZBT_HOLD = 8'h80
	} szbt_state_t;

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic [1:0] zone;
		logic read;
		logic [1:0] beats;
	} szbt_req_t;

	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} szbt_regbus_t;

	typedef struct packed {
		szbt_state_t st;
		logic [2:0][15:0] cfgs;
		szbt_zone_cfg_t cur;
		logic [1:0] zone;
		logic read;
		logic [1:0] beats;
		logic [2:0] cnt;
		logic [1:0] prev_zone;
		logic prev_valid;
		logic [15:0] rdata;
	} szbt_regs_t;

endpackage : szbt_pkg

// ---- rtl/szbt_zone_timing.sv ----
// Notes on behaviour
// - Wait field bits 2-0 adds that many wait clocks to each zone cycle.
// - Wait field is ignored while the zone's fast read bit 11 is set.
// - Hold field bits 4-3 adds that many hold clocks to a cycle.
// - Bit 5 enables burst reads; ignored when fast read is on.
// - Bit 6 adds one burst wait clock before each burst beat.
// - Bit 7 picks bus width, 0 for 8-bit, 1 for 16-bit, reset 16-bit.
// - Bit 9 adds one idle clock after a cycle when the zone changes.
// - Bit 10 adds one idle clock before a cycle entering this zone.
// - Bit 11 makes a read take one clock; otherwise reads take two or more.
// - All three zone registers reset to 069F hex.
// - Entering the I/O zone from another zone always gets an idle clock.
//
// Our own choice: the plain strobed port.
`timescale 1ns/100ps
`include "szbt_params.svh"

module szbt_zone_timing
	import szbt_pkg::*;
#(
	parameter int ADDR_W = 16
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire szbt_regbus_t regbus,
	output logic [15:0] reg_rdata,
	input wire logic req_valid,
	input wire szbt_req_t req,
	output logic req_ready,
	input wire logic [15:0] io_zone_config,
	output szbt_state_t bus_phase,
	output logic [1:0] bus_zone,
	output logic bus_read,
	output logic bus_width_16,
	output logic beat_end,
	output logic cycle_end
);

	// ****************************************
	// Decoding helpers
	// ****************************************
	function automatic logic [2:0] zone_hit(input logic [15:0] addr);
		logic [2:0] h;
		h = 3'h0;
		if (addr == `SZBT_ZONE0_OFS) begin
			h = 3'h1;
		end
		if (addr == `SZBT_ZONE1_OFS) begin
			h = 3'h2;
		end
		if (addr == `SZBT_ZONE2_OFS) begin
			h = 3'h4;
		end
		return h;
	endfunction : zone_hit

	// I/O zone settings come from outside; its register lives elsewhere
	function automatic szbt_zone_cfg_t cfg_of(input logic [2:0][15:0] cfgs,
			input logic [15:0] io_cfg, input logic [1:0] zone);
		szbt_zone_cfg_t c;
		c = szbt_zone_cfg_t'(io_cfg);
		if (zone != `SZBT_IO_ZONE) begin
			c = szbt_zone_cfg_t'(cfgs[zone]);
		end
		return c;
	endfunction : cfg_of

	localparam szbt_regs_t S_RST = '{
		st: SZBT_READY,
		cfgs: {3{`SZBT_CFG_RESET}},
		cur: szbt_zone_cfg_t'(`SZBT_CFG_RESET),
		zone: 2'h0,
		read: 1'b0,
		beats: 2'h0,
		cnt: 3'h0,
		prev_zone: 2'h0,
		prev_valid: 1'b0,
		rdata: 16'h0000
	};

	szbt_regs_t s_q;
	szbt_regs_t s_d;
	szbt_zone_cfg_t req_cfg;
	logic [2:0] hit;
	logic [2:0] weff;
	logic burst_ok;
	logic need_idle;
	logic go_after;
	logic go_finish;

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		s_d = s_q;
		go_after = 1'b0;
		go_finish = 1'b0;
		beat_end = 1'b0;
		cycle_end = 1'b0;
		hit = zone_hit(regbus.addr[15:0]);
		req_cfg = cfg_of(s_q.cfgs, io_zone_config, req.zone);
		weff = s_q.cur.fast_read_enable ? 3'h0 : s_q.cur.wait_cnt;
		burst_ok = s_q.read && s_q.cur.burst_read_enable && !s_q.cur.fast_read_enable;
		need_idle = s_q.prev_valid && (req.zone != s_q.prev_zone) &&
			(s_q.cur.idle_after_zone_change || req_cfg.idle_before_zone_change ||
			req.zone == `SZBT_IO_ZONE);

		// Register port; read data stand one cycle only
		s_d.rdata = 16'h0000;
		for (int i = 0; i < 3; i++) begin
			if (regbus.wr && hit[i]) begin
				s_d.cfgs[i] = regbus.wdata & `SZBT_CFG_WMASK;
			end
			if (regbus.rd && hit[i]) begin
				s_d.rdata = s_q.cfgs[i];
			end
		end

		unique case (s_q.st)
			SZBT_READY: begin
				if (req_valid) begin
					// Settings are frozen per cycle; a write lands on the next one
					s_d.cur = req_cfg;
					s_d.zone = req.zone;
					s_d.read = req.read;
					s_d.beats = req.beats;
					s_d.st = need_idle ? SZBT_IDLE : SZBT_T1;
				end
			end
			SZBT_IDLE: begin
				s_d.st = SZBT_T1;
			end
			SZBT_T1: begin
				if (s_q.read && s_q.cur.fast_read_enable) begin
					beat_end = 1'b1;
					go_after = 1'b1;
				end else begin
					s_d.st = SZBT_T2;
				end
			end
			SZBT_T2: begin
				if (weff != 3'h0) begin
					s_d.st = SZBT_WAIT;
					s_d.cnt = weff - 3'h1;
				end else begin
					beat_end = 1'b1;
					go_after = 1'b1;
				end
			end
			SZBT_WAIT: begin
				if (s_q.cnt == 3'h0) begin
					beat_end = 1'b1;
					go_after = 1'b1;
				end else begin
					s_d.cnt = s_q.cnt - 3'h1;
				end
			end
			SZBT_BWAIT: begin
				s_d.st = SZBT_BEAT;
			end
			SZBT_BEAT: begin
				beat_end = 1'b1;
				go_after = 1'b1;
			end
			SZBT_HOLD: begin
				if (s_q.cnt == 3'h0) begin
					go_finish = 1'b1;
				end else begin
					s_d.cnt = s_q.cnt - 3'h1;
				end
			end
			default: begin
				s_d.st = SZBT_READY;
			end
		endcase

		if (go_after) begin
			if (s_q.beats != 2'h0 && burst_ok) begin
				s_d.beats = s_q.beats - 2'h1;
				s_d.st = s_q.cur.burst_wait_add ? SZBT_BWAIT : SZBT_BEAT;
			end else if (s_q.cur.hold_cnt != 2'h0) begin
				s_d.st = SZBT_HOLD;
				s_d.cnt = {1'b0, s_q.cur.hold_cnt} - 3'h1;
			end else begin
				go_finish = 1'b1;
			end
		end

		if (go_finish) begin
			// Without burst, extra beats rerun as full cycles in the same zone
			if (s_q.beats != 2'h0) begin
				s_d.beats = s_q.beats - 2'h1;
				s_d.st = SZBT_T1;
			end else begin
				s_d.st = SZBT_READY;
				s_d.prev_zone = s_q.zone;
				s_d.prev_valid = 1'b1;
				cycle_end = 1'b1;
			end
		end
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= S_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign req_ready = (s_q.st == SZBT_READY);
	assign reg_rdata = s_q.rdata;
	assign bus_phase = s_q.st;
	assign bus_zone = s_q.zone;
	assign bus_read = s_q.read;
	assign bus_width_16 = s_q.cur.bus_width_select;

	// ****************************************
	// Checks
	// ****************************************
	logic [2:0] wait_seen_q;
	logic [2:0] hold_seen_q;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wait_seen_q <= 3'h0;
			hold_seen_q <= 3'h0;
		end else begin
			if (s_q.st == SZBT_T2) begin
				wait_seen_q <= 3'h0;
			end else if (s_q.st == SZBT_WAIT) begin
				wait_seen_q <= wait_seen_q + 3'h1;
			end
			if (s_q.st != SZBT_HOLD) begin
				hold_seen_q <= 3'h0;
			end else begin
				hold_seen_q <= hold_seen_q + 3'h1;
			end
		end
	end

	sequence s_idle_then_t1;
		(s_q.st == SZBT_IDLE) ##1 (s_q.st == SZBT_T1);
	endsequence

	sequence s_bwait_then_beat;
		(s_q.st == SZBT_BWAIT) ##1 (s_q.st == SZBT_BEAT);
	endsequence

	property p_wait_len;
		@(posedge mclk) disable iff (!rst_n)
		$fell(s_q.st == SZBT_WAIT) |-> (wait_seen_q == s_q.cur.wait_cnt);
	endproperty
	a_wait_len: assert property (p_wait_len) else $error("wait run length wrong");

	property p_fast_no_wait;
		@(posedge mclk) disable iff (!rst_n)
		(s_q.st == SZBT_T2 && s_q.cur.fast_read_enable) |=> (s_q.st != SZBT_WAIT);
	endproperty
	a_fast_no_wait: assert property (p_fast_no_wait) else $error("waits under fast read");

	property p_hold_len;
		@(posedge mclk) disable iff (!rst_n)
		$fell(s_q.st == SZBT_HOLD) |-> (hold_seen_q == {1'b0, $past(s_q.cur.hold_cnt)});
	endproperty
	a_hold_len: assert property (p_hold_len) else $error("hold run length wrong");

	property p_burst_allowed;
		@(posedge mclk) disable iff (!rst_n)
		(s_q.st == SZBT_BEAT) |-> (s_q.cur.burst_read_enable && !s_q.cur.fast_read_enable
			&& s_q.read);
	endproperty
	a_burst_allowed: assert property (p_burst_allowed) else $error("burst beat not allowed");

	property p_burst_wait;
		@(posedge mclk) disable iff (!rst_n)
		((s_q.st == SZBT_BEAT) |-> (s_q.cur.burst_wait_add == ($past(s_q.st) == SZBT_BWAIT)))
		and ((s_q.st == SZBT_BWAIT) |-> s_bwait_then_beat);
	endproperty
	a_burst_wait: assert property (p_burst_wait) else $error("burst wait mismatch");

	property p_width;
		@(posedge mclk) disable iff (!rst_n)
		(req_ready && req_valid) |=> (bus_width_16 == $past(req_cfg.bus_width_select));
	endproperty
	a_width: assert property (p_width) else $error("bus width not from zone");

	property p_idle_insert;
		@(posedge mclk) disable iff (!rst_n)
		(req_ready && req_valid && need_idle) |=> s_idle_then_t1;
	endproperty
	a_idle_insert: assert property (p_idle_insert) else $error("idle clock missing");

	property p_io_idle;
		@(posedge mclk) disable iff (!rst_n)
		(req_ready && req_valid && s_q.prev_valid && req.zone == `SZBT_IO_ZONE
			&& s_q.prev_zone != `SZBT_IO_ZONE) |=> (s_q.st == SZBT_IDLE);
	endproperty
	a_io_idle: assert property (p_io_idle) else $error("no idle entering I/O zone");

	property p_no_idle;
		@(posedge mclk) disable iff (!rst_n)
		(req_ready && req_valid && !need_idle) |=> (s_q.st == SZBT_T1);
	endproperty
	a_no_idle: assert property (p_no_idle) else $error("idle clock not wanted");

	property p_fast_one;
		@(posedge mclk) disable iff (!rst_n)
		(s_q.st == SZBT_T1 && s_q.read && s_q.cur.fast_read_enable) |-> beat_end ##1
			(s_q.st != SZBT_T2);
	endproperty
	a_fast_one: assert property (p_fast_one) else $error("fast read not one clock");

	property p_reset_val;
		@(posedge mclk)
		!rst_n |-> (s_q.cfgs == {3{`SZBT_CFG_RESET}});
	endproperty
	a_reset_val: assert property (p_reset_val) else $error("zone reset value wrong");

	property p_rsv_zero;
		@(posedge mclk) disable iff (!rst_n)
		$past(regbus.rd) |-> ((reg_rdata & `SZBT_CFG_RSV_MASK) == 16'h0000);
	endproperty
	a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits read nonzero");

	property p_zone_cfg;
		@(posedge mclk) disable iff (!rst_n)
		(req_ready && req_valid) |=> (s_q.cur == $past(req_cfg) && bus_zone == $past(req.zone));
	endproperty
	a_zone_cfg: assert property (p_zone_cfg) else $error("zone settings not latched");

endmodule : szbt_zone_timing

// ---- verif/szbt_ext_device.sv ----
`timescale 1ns/100ps
// ****************************************
// Far-side device: tallies each bus cycle's clocks and its IDLE, T1, WAIT, BWAIT and HOLD phases
// ****************************************
module szbt_ext_device
	import szbt_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire szbt_state_t bus_phase,
	input wire logic [1:0] bus_zone,
	input wire logic bus_read,
	input wire logic bus_width_16,
	input wire logic cycle_end,
	output logic [7:0] done,
	output logic [27:0] rec
);
	// Tallies stand through the READY clock after a cycle, then clear
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			done <= 8'h00;
			rec <= 28'h0;
		end else if (bus_phase == SZBT_READY) begin
			rec[23:0] <= 24'h0;
		end else begin
			rec[23:20] <= rec[23:20] + 4'h1;
			if (cycle_end) begin
				done <= done + 8'h01;
			end
			case (bus_phase)
				SZBT_IDLE: rec[19:16] <= rec[19:16] + 4'h1;
				SZBT_T1: begin
					rec[15:12] <= rec[15:12] + 4'h1;
					// Zone, direction and width seen at the first strobe only
					if (rec[15:12] == 4'h0) begin
						rec[27:24] <= {bus_zone, bus_read, bus_width_16};
					end
				end
				SZBT_WAIT: rec[11:8] <= rec[11:8] + 4'h1;
				SZBT_BWAIT: rec[7:4] <= rec[7:4] + 4'h1;
				SZBT_HOLD: rec[3:0] <= rec[3:0] + 4'h1;
				default: ;
			endcase
		end
	end
endmodule : szbt_ext_device

// ---- verif/szbt_zone_timing_bench.sv ----
`timescale 1ns/100ps
module szbt_zone_timing_bench
	import szbt_pkg::*;
;
	logic mclk = 1'b0;
	logic rst_n = 1'b1;
	szbt_regbus_t regbus = '0;
	logic [15:0] reg_rdata;
	logic req_valid = 1'b0;
	szbt_req_t req = '0;
	logic req_ready;
	logic [15:0] io_zone_config = 16'h0000;
	szbt_state_t bus_phase;
	logic [1:0] bus_zone;
	logic bus_read;
	logic bus_width_16;
	logic beat_end;
	logic cycle_end;
	logic [7:0] done;
	logic [27:0] rec;
	int errors = 0;
	int total_checks = 0;
	logic [51:0] rows [15];
	int beats_seen = 0;
	int b0;
	logic [51:0] r;
	logic [15:0] d;
	logic [27:0] seen;

	always #25 mclk = ~mclk;

	// Data beats seen by the far side, one per beat_end pulse
	always @(posedge mclk) begin
		if (beat_end === 1'b1) begin
			beats_seen <= beats_seen + 1;
		end
	end

	szbt_zone_timing szbt_zone_timing_inst (.mclk(mclk), .rst_n(rst_n), .regbus(regbus),
		.reg_rdata(reg_rdata), .req_valid(req_valid), .req(req), .req_ready(req_ready),
		.io_zone_config(io_zone_config), .bus_phase(bus_phase), .bus_zone(bus_zone),
		.bus_read(bus_read), .bus_width_16(bus_width_16), .beat_end(beat_end),
		.cycle_end(cycle_end));

	szbt_ext_device szbt_ext_device_inst (.mclk(mclk), .rst_n(rst_n), .bus_phase(bus_phase),
		.bus_zone(bus_zone), .bus_read(bus_read), .bus_width_16(bus_width_16),
		.cycle_end(cycle_end), .done(done), .rec(rec));

	// ****************************************
	// Tasks
	// ****************************************
	task chk(input logic [31:0] seen_v, input logic [31:0] exp_v);
		total_checks++;
		if (seen_v !== exp_v) begin
			errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen_v, exp_v);
		end
	endtask : chk

	task end_sim;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : end_sim

	task reg_wr(input logic [15:0] a, input logic [15:0] v);
		@(posedge mclk);
		regbus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge mclk);
		regbus.wr <= 1'b0;
	endtask : reg_wr

	task reg_rd(input logic [15:0] a, output logic [15:0] v);
		@(posedge mclk);
		regbus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge mclk);
		regbus.rd <= 1'b0;
		#1;
		v = reg_rdata;
	endtask : reg_rd

	task check_cfg_reset;
		logic [15:0] v;
		for (int i = 0; i < 3; i++) begin
			reg_rd(16'hF984 + 16'(2 * i), v);
			chk({16'h0, v}, 32'h0000_069F);
		end
	endtask : check_cfg_reset

	// Valid stays up hv edges; edges after the first meet a busy block
	task run_req(input logic [1:0] z, input logic rd, input logic [1:0] b, input int hv);
		logic [7:0] d0;
		int n;
		d0 = done;
		n = 0;
		@(posedge mclk);
		req_valid <= 1'b1;
		req <= '{zone: z, read: rd, beats: b};
		repeat (hv) @(posedge mclk);
		req_valid <= 1'b0;
		while (done === d0 && n < 100) begin
			@(posedge mclk);
			#1;
			n++;
		end
		chk({24'h0, done}, {24'h0, d0 + 8'h01});
	endtask : run_req

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		rst_n <= 1'b0;
		// last row: flash zone as advised, fast read and idle before
		rows = '{52'h0_1_0_0000_2_0_1_0_0_0, 52'h0_1_0_0087_9_0_1_7_0_0,
			52'h0_0_0_0018_5_0_1_0_0_3, 52'h1_1_0_0400_3_1_1_0_0_0,
			52'h2_1_0_0805_1_0_1_0_0_0, 52'h0_1_0_0A80_1_0_1_0_0_0,
			52'h1_1_0_0000_3_1_1_0_0_0, 52'h3_0_0_0000_3_1_1_0_0_0,
			52'h3_1_0_0002_4_0_1_2_0_0, 52'h1_1_2_0060_6_0_1_0_2_0,
			52'h1_1_2_0020_4_0_1_0_0_0, 52'h1_1_1_0820_2_0_2_0_0_0,
			52'h2_1_1_0000_4_0_2_0_0_0, 52'h0_0_0_0818_5_0_1_0_0_3,
			52'h1_1_0_0C80_2_1_1_0_0_0};
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		check_cfg_reset();
		chk({31'h0, bus_width_16}, 32'h1);
		reg_wr(16'hF984, 16'hFFFF);
		reg_rd(16'hF984, d);
		chk({16'h0, d}, 32'h0000_0EFF);
		reg_wr(16'hF98A, 16'h0000);
		reg_rd(16'hF98A, d);
		chk({16'h0, d}, 32'h0);
		reg_rd(16'hF984, d);
		chk({16'h0, d}, 32'h0000_0EFF);
		// Burst rows count every BWAIT and BEAT clock in the total
		for (int i = 0; i < 15; i++) begin
			r = rows[i];
			if (r[49:48] == 2'h3) begin
				@(posedge mclk);
				io_zone_config <= r[39:24];
			end else begin
				reg_wr(16'hF984 + {13'h0, r[49:48], 1'b0}, r[39:24]);
			end
			b0 = beats_seen;
			run_req(r[49:48], r[44], r[41:40], 1);
			seen = rec;
			chk({4'h0, seen}, {4'h0, r[49:48], r[44], r[31], r[23:0]});
			chk(32'(beats_seen - b0), {30'h0, r[41:40]} + 32'h1);
		end
		run_req(2'h0, 1'b0, 2'h0, 4);
		chk({4'h0, rec}, 32'h0050_1003);
		repeat (3) @(posedge mclk);
		#1;
		chk({24'h0, bus_phase}, {24'h0, SZBT_READY});
		@(posedge mclk);
		rst_n <= 1'b0;
		@(posedge mclk);
		rst_n <= 1'b1;
		check_cfg_reset();
		end_sim();
	end

	// Whole run is well under a thousand clocks
	initial begin
		#200000;
		errors++;
		end_sim();
	end
endmodule : szbt_zone_timing_bench
